// *** pkg/dtd_pkg.sv ***
package dtd_pkg;

   // Opcode bytes
   localparam logic [7:0] OP_MOV_TO_SEG      = 8'h8E;
   localparam logic [7:0] OP_MOV_FROM_SEG    = 8'h8C;
   localparam logic [7:0] OP_TABLE_TRANSLATE = 8'hD7;
   localparam logic [7:0] OP_LOAD_EA         = 8'h8D;
   localparam logic [7:0] OP_LOAD_FAR_DS     = 8'hC5;
   localparam logic [7:0] OP_LOAD_FAR_ES     = 8'hC4;
   localparam logic [7:0] OP_FLAGS_TO_AH     = 8'h9F;
   localparam logic [7:0] OP_AH_TO_FLAGS     = 8'h9E;

   // Addressing byte fields
   localparam int         MODE_POS      = 6;
   localparam int         REG_POS       = 3;
   localparam int         RM_POS        = 0;
   localparam logic [1:0] MODE_REG_DIRECT = 2'h3;

   // Execution clock counts
   localparam logic [5:0] CLK_TO_SEG_REG      = 6'h02;
   localparam logic [5:0] CLK_TO_SEG_MEM      = 6'h0D;
   localparam logic [5:0] CLK_FROM_SEG_REG    = 6'h02;
   localparam logic [5:0] CLK_FROM_SEG_MEM    = 6'h0F;
   localparam logic [5:0] CLK_TABLE_TRANSLATE = 6'h0F;
   localparam logic [5:0] CLK_LOAD_EA         = 6'h06;
   localparam logic [5:0] CLK_LOAD_FAR        = 6'h1A;
   localparam logic [5:0] CLK_FLAGS_TO_AH     = 6'h02;
   localparam logic [5:0] CLK_AH_TO_FLAGS     = 6'h03;
   localparam logic [5:0] CLK_WORD_PENALTY    = 6'h04;
   localparam logic [1:0] CLK_SYNC_EARLY      = 2'h1;
   localparam logic [1:0] CLK_SYNC_LATE       = 2'h2;

   // Reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [5:0] RESET_COUNT = 6'h00;

   typedef enum logic [3:0] {
      KIND_NONE,
      KIND_MOV_TO_SEG,
      KIND_MOV_FROM_SEG,
      KIND_TABLE_TRANSLATE,
      KIND_LOAD_EA,
      KIND_LOAD_FAR_DS,
      KIND_LOAD_FAR_ES,
      KIND_FLAGS_TO_AH,
      KIND_AH_TO_FLAGS,
      KIND_UNSUPPORTED
   } dtd_kind_t;

   typedef struct packed {
      dtd_kind_t  kind;
      logic [1:0] mode;
      logic [2:0] reg_f;
      logic [2:0] rm;
      logic       mem;
   } dtd_op_t;

   typedef struct packed {
      logic       we;
      logic [7:0] data;
   } dtd_wr_t;

endpackage

// *** hdl/dtd_cycle_counter.sv ***
`timescale 1ns/1ps
module dtd_cycle_counter (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       resetn,
   // Control
   input  wire logic       load,
   input  wire logic [5:0] load_val,
   // Status
   output logic [5:0]      count_q,
   output logic            last
);

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         count_q <= dtd_pkg::RESET_COUNT;
      end else if (load) begin
         count_q <= load_val;
      end else if (count_q != dtd_pkg::RESET_COUNT) begin
         count_q <= count_q - 6'h01;
      end
   end

   assign last = (count_q == 6'h01);

endmodule

// *** hdl/dtd_decoder.sv ***
// Operation
// - 8E plus addressing byte: to segment, 2/13
// - 8C plus addressing byte: from segment, 2/15
// - D7 table translate into low accumulator, 15
// - 8D loads effective address, no memory, 6
// - C5 far pointer with data segment, 26
// - C4 far pointer with extra segment, 26
// - 9F flags low byte to accumulator high, 2
// - 9E accumulator high to flags low, 3
// - Memory ops add one or two handshake clocks
// - Jump counts include destination opcode fetch
// - Word memory transfers add four clocks
`timescale 1ns/1ps
module dtd_decoder (
   // Clock and reset
   input  wire logic            clock,
   input  wire logic            resetn,
   // Prefetch queue
   input  wire logic            q_valid,
   input  wire logic [7:0]      q_byte,
   output logic                 q_ready,
   // Control flow
   input  wire logic            redirect,
   input  wire logic            word_penalty_en,
   output logic                 branch_fetched,
   // Bus interface unit
   output logic                 bus_req,
   output logic                 bus_we,
   input  wire logic            bus_done,
   input  wire logic [7:0]      bus_rdata,
   // Execution unit state
   input  wire logic [7:0]      flags_lo,
   input  wire logic [7:0]      acc_hi,
   // Results
   output dtd_pkg::dtd_op_t     op_q,
   output logic                 done,
   output logic                 fault_form,
   output logic                 fault_opcode,
   output dtd_pkg::dtd_wr_t     al_wr,
   output dtd_pkg::dtd_wr_t     ah_wr,
   output dtd_pkg::dtd_wr_t     flags_wr,
   output logic                 seg_we,
   output logic [1:0]           seg_idx,
   output logic                 reg_we,
   output logic [2:0]           reg_idx,
   output logic                 busy
);
   typedef enum logic [2:0] {
      S_OPCODE,
      S_MODRM,
      S_EXEC,
      S_WAIT_BUS,
      S_SYNC
   } dtd_state_t;
   dtd_state_t         state_q;
   dtd_pkg::dtd_op_t   op_d;
   logic               take;
   logic               load;
   logic [5:0]         load_val;
   logic [5:0]         count_q;
   logic               last;
   logic [1:0]         sync_q;
   logic               bus_seen_q;
   logic               dest_fetch_q;
   logic [7:0]         rdata_q;
   logic               finish;
   function automatic dtd_pkg::dtd_kind_t kind_of(input logic [7:0] b);
      case (b)
         dtd_pkg::OP_MOV_TO_SEG:      kind_of = dtd_pkg::KIND_MOV_TO_SEG;
         dtd_pkg::OP_MOV_FROM_SEG:    kind_of = dtd_pkg::KIND_MOV_FROM_SEG;
         dtd_pkg::OP_TABLE_TRANSLATE: kind_of = dtd_pkg::KIND_TABLE_TRANSLATE;
         dtd_pkg::OP_LOAD_EA:         kind_of = dtd_pkg::KIND_LOAD_EA;
         dtd_pkg::OP_LOAD_FAR_DS:     kind_of = dtd_pkg::KIND_LOAD_FAR_DS;
         dtd_pkg::OP_LOAD_FAR_ES:     kind_of = dtd_pkg::KIND_LOAD_FAR_ES;
         dtd_pkg::OP_FLAGS_TO_AH:     kind_of = dtd_pkg::KIND_FLAGS_TO_AH;
         dtd_pkg::OP_AH_TO_FLAGS:     kind_of = dtd_pkg::KIND_AH_TO_FLAGS;
         default:                     kind_of = dtd_pkg::KIND_UNSUPPORTED;
      endcase
   endfunction
   function automatic logic needs_modrm(input dtd_pkg::dtd_kind_t k);
      needs_modrm = (k == dtd_pkg::KIND_MOV_TO_SEG) || (k == dtd_pkg::KIND_MOV_FROM_SEG) ||
                    (k == dtd_pkg::KIND_LOAD_EA) || (k == dtd_pkg::KIND_LOAD_FAR_DS) ||
                    (k == dtd_pkg::KIND_LOAD_FAR_ES);
   endfunction
   // Which forms actually move data over the bus
   function automatic logic uses_bus(input dtd_pkg::dtd_op_t o);
      case (o.kind)
         dtd_pkg::KIND_MOV_TO_SEG,
         dtd_pkg::KIND_MOV_FROM_SEG:    uses_bus = o.mem;
         dtd_pkg::KIND_TABLE_TRANSLATE,
         dtd_pkg::KIND_LOAD_FAR_DS,
         dtd_pkg::KIND_LOAD_FAR_ES:     uses_bus = 1'b1;
         default:                       uses_bus = 1'b0;
      endcase
   endfunction
   function automatic logic [5:0] exec_clocks(input dtd_pkg::dtd_op_t o, input logic wpen);
      logic [5:0] base;
      base = dtd_pkg::CLK_LOAD_EA;
      case (o.kind)
         dtd_pkg::KIND_MOV_TO_SEG:      base = o.mem ? dtd_pkg::CLK_TO_SEG_MEM
                                                     : dtd_pkg::CLK_TO_SEG_REG;
         dtd_pkg::KIND_MOV_FROM_SEG:    base = o.mem ? dtd_pkg::CLK_FROM_SEG_MEM
                                                     : dtd_pkg::CLK_FROM_SEG_REG;
         dtd_pkg::KIND_TABLE_TRANSLATE: base = dtd_pkg::CLK_TABLE_TRANSLATE;
         dtd_pkg::KIND_LOAD_EA:         base = dtd_pkg::CLK_LOAD_EA;
         dtd_pkg::KIND_LOAD_FAR_DS,
         dtd_pkg::KIND_LOAD_FAR_ES:     base = dtd_pkg::CLK_LOAD_FAR;
         dtd_pkg::KIND_FLAGS_TO_AH:     base = dtd_pkg::CLK_FLAGS_TO_AH;
         dtd_pkg::KIND_AH_TO_FLAGS:     base = dtd_pkg::CLK_AH_TO_FLAGS;
         default:                       base = dtd_pkg::CLK_LOAD_EA;
      endcase
      // Only bus transfers pay the word penalty
      if (wpen && uses_bus(o)) begin
         base = base + dtd_pkg::CLK_WORD_PENALTY;
      end
      exec_clocks = base;
   endfunction
   // Stalls simply wait on the queue, so counts hold only if it is primed
   assign q_ready = !redirect && ((state_q == S_OPCODE) || (state_q == S_MODRM));
   assign take    = q_valid && q_ready;
   assign busy    = (state_q != S_OPCODE);
   assign finish  = !redirect &&
                    (((state_q == S_EXEC) && last && !uses_bus(op_q)) ||
                     ((state_q == S_SYNC) && (sync_q == 2'h1)));
   always_comb begin
      op_d = op_q;
      if (state_q == S_OPCODE) begin
         op_d.kind  = kind_of(q_byte);
         op_d.mode  = 2'h0;
         op_d.reg_f = 3'h0;
         op_d.rm    = 3'h0;
         op_d.mem   = (kind_of(q_byte) == dtd_pkg::KIND_TABLE_TRANSLATE);
      end else begin
         op_d.mode  = q_byte[dtd_pkg::MODE_POS +: 2];
         op_d.reg_f = q_byte[dtd_pkg::REG_POS +: 3];
         op_d.rm    = q_byte[dtd_pkg::RM_POS +: 3];
         op_d.mem   = (q_byte[dtd_pkg::MODE_POS +: 2] != dtd_pkg::MODE_REG_DIRECT);
      end
   end
   always_comb begin
      load     = 1'b0;
      load_val = exec_clocks(op_d, word_penalty_en);
      if (take) begin
         if (state_q == S_OPCODE) begin
            load = (op_d.kind != dtd_pkg::KIND_UNSUPPORTED) && !needs_modrm(op_d.kind);
         end else begin
            load = op_d.mem || !((op_d.kind == dtd_pkg::KIND_LOAD_FAR_DS) ||
                                 (op_d.kind == dtd_pkg::KIND_LOAD_FAR_ES));
         end
      end
   end
   dtd_cycle_counter i_dtd_cycle_counter (
      .clock    (clock),
      .resetn   (resetn),
      .load     (load),
      .load_val (load_val),
      .count_q  (count_q),
      .last     (last)
   );
   // Sequencing
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_q <= S_OPCODE;
      end else if (redirect) begin
         state_q <= S_OPCODE;
      end else begin
         case (state_q)
            S_OPCODE: begin
               if (take && (op_d.kind != dtd_pkg::KIND_UNSUPPORTED)) begin
                  state_q <= needs_modrm(op_d.kind) ? S_MODRM : S_EXEC;
               end
            end
            S_MODRM: begin
               if (take) begin
                  state_q <= load ? S_EXEC : S_OPCODE;
               end
            end
            S_EXEC: begin
               if (last) begin
                  state_q <= !uses_bus(op_q) ? S_OPCODE :
                             (bus_seen_q || bus_done) ? S_SYNC : S_WAIT_BUS;
               end
            end
            S_WAIT_BUS: begin
               if (bus_done) begin
                  state_q <= S_SYNC;
               end
            end
            S_SYNC: begin
               if (sync_q == 2'h1) begin
                  state_q <= S_OPCODE;
               end
            end
            default: state_q <= S_OPCODE;
         endcase
      end
   end
   // Handshake penalty: one clock if data was early, two if it was late
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sync_q <= 2'h0;
      end else if ((state_q == S_EXEC) && last && uses_bus(op_q)) begin
         sync_q <= (bus_seen_q || bus_done) ? dtd_pkg::CLK_SYNC_EARLY
                                            : dtd_pkg::CLK_SYNC_LATE;
      end else if ((state_q == S_WAIT_BUS) && bus_done) begin
         sync_q <= dtd_pkg::CLK_SYNC_LATE;
      end else if ((state_q == S_SYNC) && (sync_q != 2'h0)) begin
         sync_q <= sync_q - 2'h1;
      end
   end
   // Decoded operation
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         op_q <= '0;
      end else if (take) begin
         op_q <= op_d;
      end
   end
   // Bus request; a late reply is waited out in S_WAIT_BUS and bus_rdata is latched on bus_done, so no hold is needed
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         bus_req    <= 1'b0;
         bus_we     <= 1'b0;
         bus_seen_q <= 1'b0;
         rdata_q    <= dtd_pkg::RESET_BYTE;
      end else if (redirect) begin
         bus_req    <= 1'b0;
         bus_we     <= 1'b0;
         bus_seen_q <= 1'b0;
      end else if (load) begin
         bus_req    <= uses_bus(op_d);
         bus_we     <= (op_d.kind == dtd_pkg::KIND_MOV_FROM_SEG) && op_d.mem;
         bus_seen_q <= 1'b0;
      end else if (bus_req && bus_done) begin
         bus_req    <= 1'b0;
         bus_seen_q <= 1'b1;
         rdata_q    <= bus_rdata;
      end
   end
   // Destination opcode fetch closes a jump's count
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         dest_fetch_q   <= 1'b0;
         branch_fetched <= 1'b0;
      end else begin
         branch_fetched <= dest_fetch_q && take && (state_q == S_OPCODE);
         if (redirect) begin
            dest_fetch_q <= 1'b1;
         end else if (take && (state_q == S_OPCODE)) begin
            dest_fetch_q <= 1'b0;
         end
      end
   end
   // Faults: register-direct far load, or opcode outside this group
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         fault_form   <= 1'b0;
         fault_opcode <= 1'b0;
      end else begin
         fault_form   <= take && (state_q == S_MODRM) && !load;
         fault_opcode <= take && (state_q == S_OPCODE) &&
                         (op_d.kind == dtd_pkg::KIND_UNSUPPORTED);
      end
   end
   // Write-back strobes on the completing clock
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         done     <= 1'b0;
         al_wr    <= '0;
         ah_wr    <= '0;
         flags_wr <= '0;
         seg_we   <= 1'b0;
         seg_idx  <= 2'h0;
         reg_we   <= 1'b0;
         reg_idx  <= 3'h0;
      end else begin
         done        <= finish;
         al_wr.we    <= finish && (op_q.kind == dtd_pkg::KIND_TABLE_TRANSLATE);
         al_wr.data  <= (bus_seen_q || !bus_done) ? rdata_q : bus_rdata;
         ah_wr.we    <= finish && (op_q.kind == dtd_pkg::KIND_FLAGS_TO_AH);
         ah_wr.data  <= flags_lo;
         flags_wr.we <= finish && (op_q.kind == dtd_pkg::KIND_AH_TO_FLAGS);
         flags_wr.data <= acc_hi;
         seg_we      <= finish && ((op_q.kind == dtd_pkg::KIND_MOV_TO_SEG) ||
                                   (op_q.kind == dtd_pkg::KIND_LOAD_FAR_DS) ||
                                   (op_q.kind == dtd_pkg::KIND_LOAD_FAR_ES));
         seg_idx     <= (op_q.kind == dtd_pkg::KIND_LOAD_FAR_DS) ? 2'h3 :
                        (op_q.kind == dtd_pkg::KIND_LOAD_FAR_ES) ? 2'h0 : op_q.reg_f[1:0];
         reg_we      <= finish && ((op_q.kind == dtd_pkg::KIND_LOAD_EA) ||
                                   (op_q.kind == dtd_pkg::KIND_LOAD_FAR_DS) ||
                                   (op_q.kind == dtd_pkg::KIND_LOAD_FAR_ES) ||
                                   ((op_q.kind == dtd_pkg::KIND_MOV_FROM_SEG) && !op_q.mem));
         reg_idx     <= ((op_q.kind == dtd_pkg::KIND_MOV_FROM_SEG) ? op_q.rm : op_q.reg_f);
      end
   end
endmodule

// *** testbench/dtd_queue_model.sv ***
`timescale 1ns/1ps
module dtd_queue_model #(
   parameter int         DLY   = 2,
   parameter logic [7:0] RDATA = 8'h3C
) (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       resetn,
   // Loading
   input  wire logic       push,
   input  wire logic [7:0] push_byte,
   // Queue side
   input  wire logic       q_ready,
   output logic            q_valid,
   output logic [7:0]      q_byte,
   // Bus side
   input  wire logic       bus_req,
   output logic            bus_done,
   output logic [7:0]      bus_rdata
);
   logic [7:0] m [16];
   logic [3:0] rp;
   logic [3:0] wp;
   int         cnt;
   // Bytes are queued before the decoder asks for them
   assign q_valid = rp != wp;
   // Empty queue shows a pattern made from the read pointer, held while empty, never a stale byte
   assign q_byte = q_valid ? m[rp] : {rp, ~rp};
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rp <= 4'h0;
         wp <= 4'h0;
      end else begin
         if (push) begin
            m[wp] <= push_byte;
            wp    <= wp + 4'h1;
         end
         if (q_valid && q_ready) begin
            rp <= rp + 4'h1;
         end
      end
   end
   // Fixed reply after DLY wait clocks, no hold
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         bus_done  <= 1'b0;
         bus_rdata <= 8'h00;
         cnt       <= 0;
      end else begin
         bus_done  <= 1'b0;
         bus_rdata <= ~bus_rdata;
         if (bus_req && !bus_done && cnt == DLY) begin
            bus_done  <= 1'b1;
            bus_rdata <= RDATA;
            cnt       <= 0;
         end else if (bus_req && !bus_done) begin
            cnt <= cnt + 1;
         end else begin
            cnt <= 0;
         end
      end
   end
endmodule

// *** testbench/dtd_decoder_props.sv ***
`timescale 1ns/1ps
module dtd_decoder_props (
   // Clock and reset
   input wire logic             clock,
   input wire logic             resetn,
   // Queue and control
   input wire logic             q_valid,
   input wire logic [7:0]       q_byte,
   input wire logic             q_ready,
   input wire logic             redirect,
   input wire logic             branch_fetched,
   input wire logic             busy,
   // Bus and state
   input wire logic             bus_req,
   input wire logic             bus_done,
   input wire logic [7:0]       flags_lo,
   input wire logic [7:0]       acc_hi,
   // Results
   input wire dtd_pkg::dtd_op_t op_q,
   input wire logic             done,
   input wire logic             fault_form,
   input wire dtd_pkg::dtd_wr_t ah_wr,
   input wire dtd_pkg::dtd_wr_t flags_wr,
   input wire logic             seg_we,
   input wire logic [1:0]       seg_idx
);
   wire op_take = q_valid && q_ready && !busy;
   wire mr_take = q_valid && q_ready && busy;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   chk_ah_timing: assert property (
      (op_take && q_byte == dtd_pkg::OP_FLAGS_TO_AH) ##1 (!redirect) [*2] |=> done && ah_wr.we)
      else $error("flags copy late or missing");
   chk_ah_data: assert property (ah_wr.we |-> ah_wr.data == $past(flags_lo))
      else $error("accumulator high data wrong");
   chk_fl_timing: assert property (
      (op_take && q_byte == dtd_pkg::OP_AH_TO_FLAGS) ##1 (!redirect) [*3] |=> done && flags_wr.we)
      else $error("flags write late or missing");
   chk_fl_data: assert property (flags_wr.we |-> flags_wr.data == $past(acc_hi))
      else $error("flags data wrong");
   chk_seg_reg_move: assert property (
      (op_take && q_byte == dtd_pkg::OP_MOV_TO_SEG) ##1
      (mr_take && q_byte[7:6] == dtd_pkg::MODE_REG_DIRECT) ##1 (!redirect) [*2]
      |=> done && seg_we && seg_idx == op_q.reg_f[1:0])
      else $error("segment move from register wrong");
   chk_far_form: assert property (
      (op_take && (q_byte == dtd_pkg::OP_LOAD_FAR_ES || q_byte == dtd_pkg::OP_LOAD_FAR_DS)) ##1
      (mr_take && q_byte[7:6] == dtd_pkg::MODE_REG_DIRECT) |=> fault_form && !done)
      else $error("register form of far load accepted");
   chk_far_ds_seg: assert property (
      done && op_q.kind == dtd_pkg::KIND_LOAD_FAR_DS |-> seg_we && seg_idx == 2'h3)
      else $error("far load missed data segment");
   chk_ea_no_bus: assert property (
      done && op_q.kind == dtd_pkg::KIND_LOAD_EA |-> !$past(bus_req))
      else $error("effective address load used the bus");
   chk_bus_release: assert property (bus_done && bus_req |=> !bus_req)
      else $error("bus request held after completion");
   chk_redirect_drop: assert property (redirect |=> (!done) [*3])
      else $error("op completed across a redirect");
   chk_branch_take: assert property (branch_fetched |-> $past(op_take))
      else $error("branch fetch pulse without opcode take");
endmodule
bind dtd_decoder dtd_decoder_props i_dtd_decoder_props (
   .clock(clock), .resetn(resetn), .q_valid(q_valid), .q_byte(q_byte), .q_ready(q_ready),
   .redirect(redirect), .branch_fetched(branch_fetched), .busy(busy), .bus_req(bus_req),
   .bus_done(bus_done), .flags_lo(flags_lo), .acc_hi(acc_hi), .op_q(op_q), .done(done),
   .fault_form(fault_form), .ah_wr(ah_wr), .flags_wr(flags_wr), .seg_we(seg_we),
   .seg_idx(seg_idx));

// *** testbench/data_transfer_opcode_decoder_tb.sv ***
`timescale 1ns/1ps
module data_transfer_opcode_decoder_tb;
   logic             clock, resetn, push, redirect, word_penalty_en, q_valid, q_ready;
   logic [7:0]       push_byte, q_byte, flags_lo, acc_hi, bus_rdata;
   logic             branch_fetched, bus_req, bus_we, bus_done, done, fault_form;
   logic             fault_opcode, seg_we, reg_we, busy, c_seg_we, c_reg_we, c_ff, c_fo;
   logic             seen_req, seen_we, seen_bf;
   logic [1:0]       seg_idx, c_seg_idx;
   logic [2:0]       reg_idx, c_reg_idx;
   dtd_pkg::dtd_op_t op_q, c_op;
   dtd_pkg::dtd_wr_t al_wr, ah_wr, flags_wr, c_al, c_ah, c_fl;
   int               fails = 0, comparisons = 0, cyc = 0, t_take = 0, lat = 0, ends = 0;
   dtd_decoder i_dtd_decoder (
      .clock(clock), .resetn(resetn), .q_valid(q_valid), .q_byte(q_byte), .q_ready(q_ready),
      .redirect(redirect), .word_penalty_en(word_penalty_en), .branch_fetched(branch_fetched),
      .bus_req(bus_req), .bus_we(bus_we), .bus_done(bus_done), .bus_rdata(bus_rdata),
      .flags_lo(flags_lo), .acc_hi(acc_hi), .op_q(op_q), .done(done), .fault_form(fault_form),
      .fault_opcode(fault_opcode), .al_wr(al_wr), .ah_wr(ah_wr), .flags_wr(flags_wr),
      .seg_we(seg_we), .seg_idx(seg_idx), .reg_we(reg_we), .reg_idx(reg_idx), .busy(busy));
   dtd_queue_model i_dtd_queue_model (
      .clock(clock), .resetn(resetn), .push(push), .push_byte(push_byte), .q_ready(q_ready),
      .q_valid(q_valid), .q_byte(q_byte), .bus_req(bus_req), .bus_done(bus_done),
      .bus_rdata(bus_rdata));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task automatic tally_and_finish;
      if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Snapshot taken at the edge that ends an op, latency from the last byte taken
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (q_valid && q_ready) t_take <= cyc;
      if (bus_req) seen_req <= 1'b1;
      if (bus_we) seen_we <= 1'b1;
      if (branch_fetched) seen_bf <= 1'b1;
      if (done || fault_form || fault_opcode) begin
         ends      <= ends + 1;
         lat       <= cyc - t_take;
         {c_al, c_ah, c_fl, c_op} <= {al_wr, ah_wr, flags_wr, op_q};
         {c_seg_we, c_seg_idx, c_reg_we, c_reg_idx} <= {seg_we, seg_idx, reg_we, reg_idx};
         {c_ff, c_fo} <= {fault_form, fault_opcode};
      end
      if (cyc == 5000) begin
         fails++;
         tally_and_finish;
      end
   end
   task automatic cmp_v(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cmp_b(input string n, input logic e, input logic g);
      cmp_v(n, {7'h00, e}, {7'h00, g});
   endtask
   task automatic cmp_n(input string n, input int e, input int g);
      comparisons++;
      if (g != e) begin
         fails++;
         $display("[FAIL] %s expected %0d seen %0d", n, e, g);
      end
   endtask
   task automatic put(input logic [7:0] b);
      @(posedge clock);
      push      <= 1'b1;
      push_byte <= b;
      @(posedge clock);
      push      <= 1'b0;
   endtask
   task automatic run(input logic [7:0] op, input logic [7:0] m, input bit mr);
      int n0;
      n0 = ends;
      {seen_req, seen_we, seen_bf} <= 3'h0;
      @(posedge clock);
      push      <= 1'b1;
      push_byte <= op;
      if (mr) begin
         @(posedge clock);
         push_byte <= m;
      end
      @(posedge clock);
      push      <= 1'b0;
      for (int i = 0; i < 80 && ends == n0; i++) @(posedge clock);
      @(posedge clock);
      cmp_n("op end", n0 + 1, ends);
      cmp_b("idle after op", 1'b0, busy);
      cmp_b("ready after op", 1'b1, q_ready);
   endtask
   task automatic t_flags;
      flags_lo <= 8'h5A;
      acc_hi   <= 8'hC3;
      run(dtd_pkg::OP_FLAGS_TO_AH, 8'h00, 1'b0);
      cmp_n("ah latency", 3, lat);
      cmp_v("ah data", 8'h5A, c_ah.data);
      run(dtd_pkg::OP_AH_TO_FLAGS, 8'h00, 1'b0);
      cmp_n("flags latency", 4, lat);
      cmp_v("flags data", 8'hC3, c_fl.data);
   endtask
   task automatic t_seg_moves;
      run(dtd_pkg::OP_MOV_TO_SEG, 8'hD8, 1'b1);
      cmp_n("to seg reg latency", 3, lat);
      cmp_v("to seg idx", 8'h03, {6'h00, c_seg_idx});
      run(dtd_pkg::OP_MOV_TO_SEG, 8'h18, 1'b1);
      cmp_n("to seg mem latency", 15, lat);
      run(dtd_pkg::OP_MOV_FROM_SEG, 8'hC1, 1'b1);
      cmp_n("from seg reg latency", 3, lat);
      cmp_b("from seg reg we", 1'b1, c_reg_we);
      run(dtd_pkg::OP_MOV_FROM_SEG, 8'h00, 1'b1);
      cmp_n("from seg mem latency", 17, lat);
      cmp_b("from seg bus write", 1'b1, seen_we);
   endtask
   task automatic t_translate;
      run(dtd_pkg::OP_TABLE_TRANSLATE, 8'h00, 1'b0);
      cmp_n("xlt latency", 17, lat);
      cmp_v("xlt al data", 8'h3C, c_al.data);
      cmp_b("xlt al we", 1'b1, c_al.we);
      word_penalty_en <= 1'b1;
      run(dtd_pkg::OP_TABLE_TRANSLATE, 8'h00, 1'b0);
      cmp_n("xlt word latency", 21, lat);
      word_penalty_en <= 1'b0;
   endtask
   task automatic t_ea_far;
      run(dtd_pkg::OP_LOAD_EA, 8'h18, 1'b1);
      cmp_n("ea latency", 7, lat);
      cmp_b("ea bus", 1'b0, seen_req);
      cmp_v("ea reg idx", 8'h03, {5'h00, c_reg_idx});
      cmp_v("ea fields", 8'h18, {c_op.mode, c_op.reg_f, c_op.rm});
      run(dtd_pkg::OP_LOAD_FAR_DS, 8'h08, 1'b1);
      cmp_n("far ds latency", 28, lat);
      cmp_v("far ds seg", 8'h03, {6'h00, c_seg_idx});
      run(dtd_pkg::OP_LOAD_FAR_ES, 8'h08, 1'b1);
      cmp_n("far es latency", 28, lat);
      cmp_v("far es seg", 8'h00, {6'h00, c_seg_idx});
      run(dtd_pkg::OP_LOAD_FAR_ES, 8'hC8, 1'b1);
      cmp_b("far es form", 1'b1, c_ff);
      run(dtd_pkg::OP_LOAD_FAR_DS, 8'hC0, 1'b1);
      cmp_b("far ds form", 1'b1, c_ff);
      run(8'h90, 8'h00, 1'b0);
      cmp_b("foreign opcode", 1'b1, c_fo);
   endtask
   task automatic t_redirect;
      int n0;
      n0 = ends;
      put(dtd_pkg::OP_TABLE_TRANSLATE);
      repeat (4) @(posedge clock);
      redirect <= 1'b1;
      @(posedge clock);
      redirect <= 1'b0;
      run(dtd_pkg::OP_FLAGS_TO_AH, 8'h00, 1'b0);
      cmp_b("dest fetch pulse", 1'b1, seen_bf);
      cmp_b("aborted al write", 1'b0, c_al.we);
      cmp_b("dest op ah write", 1'b1, c_ah.we);
      repeat (30) @(posedge clock);
      cmp_n("ends across redirect", n0 + 1, ends);
   endtask
   initial begin
      {resetn, push, redirect, word_penalty_en} = 4'h0;
      {push_byte, flags_lo, acc_hi} = 24'h000000;
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      t_flags;
      t_seg_moves;
      t_translate;
      t_ea_far;
      t_redirect;
      tally_and_finish;
   end
endmodule
